// File: hdl/amcr_pkg.sv
package amcr_pkg;
  // control word layout
  localparam int WORD_W  = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 12;
  localparam int RW_BIT  = 11;
  localparam int DATA_W  = 10;
  localparam logic       RW_WRITE = 1'b0;   // write flag value in a control word

  // register addresses
  localparam logic [3:0] ADDR_CORE = 4'h0;  // converter_core_control
  localparam logic [3:0] ADDR_FMT  = 4'h1;  // format_and_port_control

  // converter_core_control fields
  localparam int CORE_RATE_BIT = 6;
  localparam int CORE_PD_BIT   = 7;
  localparam int CORE_HPE_BIT  = 8;
  localparam int CORE_PEAK_BIT = 9;

  // format_and_port_control fields
  localparam int FMT_MUTE_LO = 0;           // bit 0 left mute, bit 1 right mute
  localparam int FMT_ROLE    = 2;
  localparam int FMT_WW_LO   = 3;
  localparam int FMT_DF_LO   = 5;
  localparam int FMT_BYP     = 7;

  // reset values and write mask
  localparam logic [9:0] CORE_RESET = 10'h000;
  localparam logic [9:0] FMT_RESET  = 10'h000;
  localparam logic [9:0] FMT_WMASK  = 10'h0FF; // bits 9 and 8 never stored

  // modulator oversampling ratios
  localparam logic [7:0] MOD_RATIO_NORMAL = 8'h80; // 128
  localparam logic [7:0] MOD_RATIO_FAST   = 8'h40; // 64

  // sample path
  localparam int SAMPLE_W = 24;
  localparam int HP_SHIFT = 8;              // dc tracker time constant, 2^8 samples
  localparam int MOD_W    = 4;
  localparam logic [23:0] MASK_24 = 24'hFF_FFFF;
  localparam logic [23:0] MASK_20 = 24'hFF_FFF0;
  localparam logic [23:0] MASK_16 = 24'hFF_FF00;

  // master clock generation
  localparam logic [3:0] BCLK_HALF = 4'h2;  // clk cycles per bit clock half period
  localparam logic [4:0] LR_LAST   = 5'h1F; // 32 bit clocks per frame half

  typedef enum logic [1:0] {
    AMCR_FMT_I2S = 2'b00,
    AMCR_FMT_RJ  = 2'b01,
    AMCR_FMT_DSP = 2'b10,
    AMCR_FMT_LJ  = 2'b11
  } amcr_fmt_e;

  typedef enum logic [1:0] {
    AMCR_WW_24  = 2'b00,
    AMCR_WW_20  = 2'b01,
    AMCR_WW_16  = 2'b10,
    AMCR_WW_RSV = 2'b11
  } amcr_ww_e;
endpackage

// File: hdl/amcr_shift.sv
`timescale 1ns/1ps
// serial control word receiver: shifts cdata on cclk rising edges while
// the latch line is low, hands the word over when the latch line rises
module amcr_shift
  import amcr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              cclk,
  input  wire logic              clatch_n,
  input  wire logic              cdata,
  output logic [WORD_W-1:0]      word_r,
  output logic                   word_valid_r
);
  logic              cclk_d_r;    // previous cclk level
  logic              latch_d_r;   // previous latch level
  logic [WORD_W-1:0] shift_r;     // msb-first shift register
  wire               cclk_rise  = cclk & ~cclk_d_r;
  wire               latch_rise = clatch_n & ~latch_d_r;

  // edge history; inputs are already in the clk domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cclk_d_r  <= 1'b1;  // idle level of cclk, so no false rise after reset
      latch_d_r <= 1'b1;
    end else begin
      cclk_d_r  <= cclk;
      latch_d_r <= clatch_n;
    end
  end

  // shift while selected, keep only the last 16 bits seen
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_r <= '0;
    end else if (cclk_rise && !clatch_n) begin
      shift_r <= {shift_r[WORD_W-2:0], cdata};
    end
  end

  // a cascaded chain may shift more than 16 bits; the last 16 are ours
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_r       <= '0;
      word_valid_r <= 1'b0;
    end else begin
      word_valid_r <= latch_rise;
      if (latch_rise) begin
        word_r <= shift_r;
      end
    end
  end
endmodule // amcr_shift

// File: hdl/amcr_regs.sv
`timescale 1ns/1ps
module adc_mode_control_regs
  import amcr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                cclk,          // control port serial clock
  input  wire logic                clatch_n,      // control port select, low active
  input  wire logic                cdata,         // control port data in
  output logic                     cout,          // control port data out
  input  wire logic [SAMPLE_W-1:0] adc_left,      // decimated left sample
  input  wire logic [SAMPLE_W-1:0] adc_right,     // decimated right sample
  input  wire logic [MOD_W-1:0]    mod_bits,      // raw modulator output
  input  wire logic                adc_valid,     // sample strobe
  output logic [SAMPLE_W-1:0]      out_left,
  output logic [SAMPLE_W-1:0]      out_right,
  output logic                     out_valid,
  output logic [7:0]               mod_ratio,     // modulator clock / sample rate
  output logic                     analog_pd,     // analog power down, reference kept
  output logic                     peak_capture_en,
  output logic [1:0]               interface_format_field,
  output logic [1:0]               sample_width_field,
  output logic [4:0]               word_bits,     // 24, 20 or 16
  output logic                     bclk_o,
  output logic                     bclk_oe_n,
  output logic                     lrclk_o,
  output logic                     lrclk_oe_n
);
  logic [WORD_W-1:0]   word_r;          // last received control word
  logic                word_valid_r;    // one-cycle pulse per word
  logic [DATA_W-1:0]   core_r;          // converter_core_control
  logic [DATA_W-1:0]   fmt_r;           // format_and_port_control
  logic [SAMPLE_W-1:0] out_r [2];       // channel outputs
  logic                out_valid_r;
  logic [7:0]          mod_ratio_r;
  logic                analog_pd_r;
  logic                peak_en_r;
  logic [4:0]          word_bits_r;
  logic                cout_r;
  logic [3:0]          div_r;           // bit clock half period counter
  logic [4:0]          bcnt_r;          // bit clocks within frame half
  logic                bclk_r;
  logic                lrclk_r;
  logic                oe_n_r;

  amcr_shift u_shift (
    .clk          (clk),
    .resetn       (resetn),
    .cclk         (cclk),
    .clatch_n     (clatch_n),
    .cdata        (cdata),
    .word_r       (word_r),
    .word_valid_r (word_valid_r)
  );

  // field decode of the control word
  wire [3:0]        word_addr = word_r[ADDR_HI:ADDR_LO];
  wire              word_wr   = word_valid_r && (word_r[RW_BIT] == RW_WRITE);
  wire [DATA_W-1:0] word_data = word_r[DATA_W-1:0];
  wire              wr_core   = word_wr && (word_addr == ADDR_CORE);
  wire              wr_fmt    = word_wr && (word_addr == ADDR_FMT);

  // named control bits
  wire       modulator_rate_select   = core_r[CORE_RATE_BIT];
  wire       powerdown_bit           = core_r[CORE_PD_BIT];
  wire       highpass_enable         = core_r[CORE_HPE_BIT];
  wire       peak_bit                = core_r[CORE_PEAK_BIT];
  wire       modulator_bypass_enable = fmt_r[FMT_BYP];
  wire       slave_role              = fmt_r[FMT_ROLE];
  wire [1:0] fmt_field               = fmt_r[FMT_DF_LO+1:FMT_DF_LO];
  wire [1:0] ww_field                = fmt_r[FMT_WW_LO+1:FMT_WW_LO];
  wire       sample_take             = adc_valid && !powerdown_bit;

  // register writes; other addresses and reads are ignored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_r <= CORE_RESET;
      fmt_r  <= FMT_RESET;
    end else begin
      if (wr_core) begin
        core_r <= word_data;
      end
      if (wr_fmt) begin
        fmt_r <= word_data & FMT_WMASK;
      end
    end
  end

  // width mask; the reserved code falls back to full width
  wire [SAMPLE_W-1:0] wmask = (ww_field == AMCR_WW_20) ? MASK_20 :
                              (ww_field == AMCR_WW_16) ? MASK_16 : MASK_24;
  wire [4:0] width_bits     = (ww_field == AMCR_WW_20) ? 5'h14 :
                              (ww_field == AMCR_WW_16) ? 5'h10 : 5'h18;

  // per-channel path: high-pass, bypass, width, mute
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic signed [SAMPLE_W-1:0] dc_r;   // running dc estimate
      wire signed [SAMPLE_W-1:0] x_w  = (ch == 0) ? adc_left : adc_right;
      wire signed [SAMPLE_W-1:0] hp_w = x_w - dc_r;
      wire [SAMPLE_W-1:0] filt_w = highpass_enable ? hp_w : x_w;
      wire [SAMPLE_W-1:0] raw_w  = {{(SAMPLE_W-MOD_W){1'b0}}, mod_bits};
      wire [SAMPLE_W-1:0] sel_w  = modulator_bypass_enable ? raw_w : filt_w;
      wire [SAMPLE_W-1:0] fin_w  = fmt_r[FMT_MUTE_LO+ch] ? '0 : (sel_w & wmask);

      // dc tracker is cleared while disabled so a later enable starts clean
      always_ff @(posedge clk) begin
        if (!resetn || !highpass_enable) begin
          dc_r <= '0;
        end else if (sample_take) begin
          dc_r <= dc_r + (hp_w >>> HP_SHIFT);
        end
      end

      // output register holds its value while powered down
      always_ff @(posedge clk) begin
        if (!resetn) begin
          out_r[ch] <= '0;
        end else if (sample_take) begin
          out_r[ch] <= fin_w;
        end
      end
    end
  endgenerate

  // status and mode outputs, registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid_r <= 1'b0;
      mod_ratio_r <= MOD_RATIO_NORMAL;
      analog_pd_r <= 1'b0;
      peak_en_r   <= 1'b0;
      word_bits_r <= 5'h18;
      cout_r      <= 1'b0;
    end else begin
      out_valid_r <= sample_take;
      mod_ratio_r <= modulator_rate_select ? MOD_RATIO_FAST : MOD_RATIO_NORMAL;
      analog_pd_r <= powerdown_bit;
      peak_en_r   <= peak_bit && !powerdown_bit;
      word_bits_r <= width_bits;
      cout_r      <= 1'b0;  // no readback is served by this block
    end
  end

  // master clocks; slave role or power-down stops them, only slave role releases the pins
  wire clk_active = !slave_role && !powerdown_bit;
  wire half_done  = (div_r == BCLK_HALF - 4'h1);
  always_ff @(posedge clk) begin
    if (!resetn || !clk_active) begin
      div_r   <= '0;
      bclk_r  <= 1'b0;
      bcnt_r  <= '0;
      lrclk_r <= 1'b0;
    end else if (half_done) begin
      div_r  <= '0;
      bclk_r <= ~bclk_r;
      if (bclk_r) begin
        bcnt_r <= bcnt_r + 5'h1;
        if (bcnt_r == LR_LAST) begin
          lrclk_r <= ~lrclk_r;
        end
      end
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // pins released in slave role so the controller can drive them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oe_n_r <= 1'b0;
    end else begin
      oe_n_r <= slave_role;
    end
  end

  assign out_left               = out_r[0];
  assign out_right              = out_r[1];
  assign out_valid              = out_valid_r;
  assign mod_ratio              = mod_ratio_r;
  assign analog_pd              = analog_pd_r;
  assign peak_capture_en        = peak_en_r;
  assign interface_format_field = fmt_field;
  assign sample_width_field     = ww_field;
  assign word_bits              = word_bits_r;
  assign cout                   = cout_r;
  assign bclk_o                 = bclk_r;
  assign lrclk_o                = lrclk_r;
  assign bclk_oe_n              = oe_n_r;
  assign lrclk_oe_n             = oe_n_r;

  // checks
  sequence s_core_write;
    wr_core;
  endsequence
  sequence s_fmt_write;
    wr_fmt;
  endsequence

  a_core_write_load: assert property (@(posedge clk) disable iff (!resetn)
    s_core_write |=> (core_r == $past(word_data)))
    else $error("core register not loaded from word");
  a_fmt_resv_ignored: assert property (@(posedge clk) disable iff (!resetn)
    s_fmt_write |=> (fmt_r[9:8] == 2'b00) && (fmt_r[7:0] == $past(word_data[7:0])))
    else $error("format register load wrong");
  a_rate_ratio_fast: assert property (@(posedge clk) disable iff (!resetn)
    modulator_rate_select |=> (mod_ratio_r == MOD_RATIO_FAST))
    else $error("modulator ratio not 64");
  a_rate_ratio_norm: assert property (@(posedge clk) disable iff (!resetn)
    !modulator_rate_select |=> (mod_ratio_r == MOD_RATIO_NORMAL))
    else $error("modulator ratio not 128");
  a_pd_clocks_stop: assert property (@(posedge clk) disable iff (!resetn)
    powerdown_bit |=> !bclk_r && !lrclk_r && !out_valid_r && analog_pd_r)
    else $error("activity during power down");
  a_peak_enable: assert property (@(posedge clk) disable iff (!resetn)
    (peak_bit && !powerdown_bit) |=> peak_en_r)
    else $error("peak capture not enabled");
  a_hp_off_pass: assert property (@(posedge clk) disable iff (!resetn)
    (sample_take && !highpass_enable && !modulator_bypass_enable && !fmt_r[0]
     && ww_field == AMCR_WW_24) |=> (out_left == $past(adc_left)))
    else $error("sample altered with filter off");
  a_bypass_raw: assert property (@(posedge clk) disable iff (!resetn)
    (sample_take && modulator_bypass_enable && !fmt_r[1]) |=>
      (out_right == ({{(SAMPLE_W-MOD_W){1'b0}}, $past(mod_bits)} & $past(wmask))))
    else $error("bypass output not raw modulator");
  a_mute_zero: assert property (@(posedge clk) disable iff (!resetn)
    (sample_take && fmt_r[0]) |=> (out_left == '0))
    else $error("muted left not zero");
  a_width_16_mask: assert property (@(posedge clk) disable iff (!resetn)
    (sample_take && ww_field == AMCR_WW_16) |=> (out_right[7:0] == 8'h00))
    else $error("16-bit width low bits not clear");
  a_slave_release: assert property (@(posedge clk) disable iff (!resetn)
    slave_role |=> bclk_oe_n && lrclk_oe_n && !bclk_r)
    else $error("pins driven in slave role");
  a_master_toggle: assert property (@(posedge clk) disable iff (!resetn)
    (clk_active && half_done) ##1 clk_active |-> !bclk_oe_n && (bclk_r != $past(bclk_r)))
    else $error("master bit clock not toggling");
endmodule // adc_mode_control_regs

// File: tb/amcr_host.sv
`timescale 1ns/1ps
// host side of the serial control port, writes one word per call
module amcr_host (
  input  wire logic clk,       // system clock, host paces its edges on it
  output logic      cclk,      // serial clock, rests high between words
  output logic      clatch_n,  // word select, low active
  output logic      cdata      // serial data
);
  // idle state before the first word
  initial begin
    cclk     = 1'b1;
    clatch_n = 1'b1;
    cdata    = 1'b0;
  end

  // each cclk level lasts three clk cycles so the oversampler sees it
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    clatch_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      cclk  = 1'b0;
      cdata = w[i];
      repeat (3) @(negedge clk);
      cclk = 1'b1;
      repeat (2) @(negedge clk);
    end
    @(negedge clk);
    clatch_n = 1'b1;
    // released data line must not keep looking like the last bit
    cdata = ~cdata;
    repeat (3) @(negedge clk);
  endtask
endmodule  // amcr_host

// File: tb/test_adc_mode_control_regs.sv
`timescale 1ns/1ps
module test_adc_mode_control_regs;
  import amcr_pkg::*;
  logic               clk, resetn, cclk, clatch_n, cdata, cout, adc_valid, out_valid;
  logic [23:0]        adc_left, adc_right, out_left, out_right;
  logic [3:0]         mod_bits;
  logic [7:0]         mod_ratio;
  logic               analog_pd, peak_capture_en, bclk_o, bclk_oe_n, lrclk_o, lrclk_oe_n;
  logic [1:0]         interface_format_field, sample_width_field;
  logic [4:0]         word_bits;
  logic [9:0]         core_v, fmt_v;   // expected register contents
  logic signed [23:0] dc_l, dc_r;      // expected dc trackers
  logic [47:0]        exp_q[$];        // expected {left, right} results
  logic [47:0]        want;
  int                 fail_count, checks_done;

  amcr_host u_host (.clk(clk), .cclk(cclk), .clatch_n(clatch_n), .cdata(cdata));

  adc_mode_control_regs dut (.clk(clk), .resetn(resetn), .cclk(cclk), .clatch_n(clatch_n),
    .cdata(cdata), .cout(cout), .adc_left(adc_left), .adc_right(adc_right),
    .mod_bits(mod_bits), .adc_valid(adc_valid), .out_left(out_left), .out_right(out_right),
    .out_valid(out_valid), .mod_ratio(mod_ratio), .analog_pd(analog_pd),
    .peak_capture_en(peak_capture_en), .interface_format_field(interface_format_field),
    .sample_width_field(sample_width_field), .word_bits(word_bits), .bclk_o(bclk_o),
    .bclk_oe_n(bclk_oe_n), .lrclk_o(lrclk_o), .lrclk_oe_n(lrclk_oe_n));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bypass, width mask, then mute, in the order the sample path applies them
  function automatic logic [23:0] post(input logic [23:0] x, input logic [3:0] m,
                                       input logic mu);
    logic [23:0] v;
    v = fmt_v[7] ? {20'h0_0000, m} : x;
    if (fmt_v[4:3] == 2'b01) v = v & 24'hFF_FFF0;
    if (fmt_v[4:3] == 2'b10) v = v & 24'hFF_FF00;
    return mu ? 24'h00_0000 : v;
  endfunction

  // one control word, then time for the mode outputs to settle
  task automatic wr(input logic [3:0] a, input logic rw, input logic [9:0] d);
    u_host.send({a, rw, 1'b0, d});
    if (rw == RW_WRITE && a == ADDR_FMT) fmt_v = d & 10'h0FF;
    if (rw == RW_WRITE && a == ADDR_CORE) core_v = d;
    if (!core_v[8]) dc_l = 24'h00_0000;
    if (!core_v[8]) dc_r = 24'h00_0000;
    repeat (5) @(negedge clk);
  endtask

  task automatic chk_cfg;
    check(mod_ratio, core_v[6] ? 8'h40 : 8'h80);
    check(analog_pd, core_v[7]);
    check(peak_capture_en, core_v[9] & ~core_v[7]);
    check(interface_format_field, fmt_v[6:5]);
    check(sample_width_field, fmt_v[4:3]);
    check(word_bits, fmt_v[4:3] == 2'b01 ? 5'h14 :
          fmt_v[4:3] == 2'b10 ? 5'h10 : 5'h18);
    check(bclk_oe_n, fmt_v[2]);
    check(lrclk_oe_n, fmt_v[2]);
    check(cout, 1'b0);
  endtask

  // one strobe; the expected result is noted unless power-down refuses it
  task automatic sample(input logic [23:0] l, input logic [23:0] r, input logic [3:0] m);
    logic signed [23:0] yl;
    logic signed [23:0] yr;
    yl = l - dc_l;
    yr = r - dc_r;
    if (core_v[8] && !core_v[7]) dc_l = dc_l + (yl >>> 8);
    if (core_v[8] && !core_v[7]) dc_r = dc_r + (yr >>> 8);
    if (!core_v[7]) exp_q.push_back({post(yl, m, fmt_v[0]), post(yr, m, fmt_v[1])});
    adc_left  = l;
    adc_right = r;
    mod_bits  = m;
    adc_valid = 1'b1;
    @(negedge clk);
    adc_valid = 1'b0;
    @(negedge clk);
  endtask

  // count clock line changes over 256 cycles
  task automatic clocks(input int nb_exp, input int nl_exp);
    int   nb;
    int   nl;
    logic pb;
    logic pl;
    nb = 0;
    nl = 0;
    pb = bclk_o;
    pl = lrclk_o;
    repeat (256) begin
      @(negedge clk);
      nb += int'(bclk_o !== pb);
      nl += int'(lrclk_o !== pl);
      pb = bclk_o;
      pl = lrclk_o;
    end
    check(24'(nb), 24'(nb_exp));
    check(24'(nl), 24'(nl_exp));
  endtask

  // result watcher: every out_valid consumes the oldest note
  always @(negedge clk) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) check(24'h00_0001, 24'h00_0000);
      else begin
        want = exp_q.pop_front();
        check(out_left, want[47:24]);
        check(out_right, want[23:0]);
      end
    end
  end

  // watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #500_000;
    fail_count++;
    summarize();
  end

  initial begin
    clk = 0;
    resetn = 0;
    adc_valid = 0;
    adc_left = 0;
    adc_right = 0;
    mod_bits = 0;
    core_v = 0;
    fmt_v = 0;
    dc_l = 0;
    dc_r = 0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(42));
    repeat (20) @(negedge clk);
    resetn = 1;
    repeat (2) @(negedge clk);
    chk_cfg();
    clocks(128, 2);
    // every format and width code, random mutes and samples
    for (int f = 0; f < 16; f++) begin
      wr(ADDR_FMT, RW_WRITE, {3'b000, 4'(f), 1'b0, 2'($urandom)});
      chk_cfg();
      repeat (2) sample(24'($urandom), 24'($urandom), 4'($urandom));
    end
    // raw modulator bits replace the decimated samples
    wr(ADDR_FMT, RW_WRITE, 10'h080);
    repeat (2) sample(24'($urandom), 24'($urandom), 4'($urandom));
    // constant input loses its dc part step by step
    wr(ADDR_FMT, RW_WRITE, 10'h000);
    wr(ADDR_CORE, RW_WRITE, 10'h100);
    repeat (3) sample(24'h10_0000, 24'hF0_0000, 4'h0);
    wr(ADDR_CORE, RW_WRITE, 10'h240);
    chk_cfg();
    // a read word and an unmapped address change nothing
    wr(ADDR_CORE, 1'b1, 10'h080);
    wr(4'h3, RW_WRITE, 10'h3FF);
    chk_cfg();
    // reserved bits dropped; slave role hands both clocks to the host
    wr(ADDR_FMT, RW_WRITE, 10'h304);
    chk_cfg();
    clocks(0, 0);
    // power-down: clocks stopped low, samples refused
    wr(ADDR_FMT, RW_WRITE, 10'h000);
    wr(ADDR_CORE, RW_WRITE, 10'h280);
    chk_cfg();
    clocks(0, 0);
    check(bclk_o | lrclk_o, 1'b0);
    sample(24'($urandom), 24'($urandom), 4'h0);
    repeat (4) @(negedge clk);
    check(24'(exp_q.size()), 24'h00_0000);
    // mid-run reset brings every register back to its default
    resetn = 0;
    repeat (2) @(negedge clk);
    resetn = 1;
    core_v = 0;
    fmt_v = 0;
    dc_l = 0;
    dc_r = 0;
    repeat (2) @(negedge clk);
    chk_cfg();
    clocks(128, 2);
    summarize();
  end
endmodule  // test_adc_mode_control_regs
